// ---- logic/stbt_pkg.sv ----
// Constants, field layouts and types for the serial trace byte transmitter.
// Assumes one clock (ref_clk) and a synchronous, active-high reset.
//
// Function
// - A data register write with enable set starts one transfer
// - Byte goes out LSB first, one per transfer
// - Edge select 1 shifts on fall, 0 rise
// - Clock and data idle high between transfers
// - Data read returns last written byte, else 00h
// - Gap field inserts N+1 clock periods between packets
// - Divider select gives 24, 12, 6 MHz; 11 reserved
// - Trace clock divided from 48 MHz ring oscillator
// - Enable bit turns trace clock on, resets off
// - Reset clears every register and all logic
// - Block raises no interrupt at all
`default_nettype none

package stbt_pkg;

  // Register offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;

  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;

  // Control register field positions
  localparam int unsigned GAP_MSB = 6;
  localparam int unsigned GAP_LSB = 4;
  localparam int unsigned DIV_MSB = 3;
  localparam int unsigned DIV_LSB = 2;
  localparam int unsigned EDGE_BIT = 1;
  localparam int unsigned EN_BIT = 0;

  // Divider select codes
  localparam logic [1:0] DIVSEL_24 = 2'h0;
  localparam logic [1:0] DIVSEL_12 = 2'h1;
  localparam logic [1:0] DIVSEL_6 = 2'h2;

  // Clock rates in MHz
  localparam int unsigned RING_MHZ = 48;
  localparam int unsigned TRACE_MHZ_24 = 24;
  localparam int unsigned TRACE_MHZ_12 = 12;
  localparam int unsigned TRACE_MHZ_6 = 6;

  // Ring oscillator rising edges per trace clock half period
  localparam logic [2:0] HALF_24 = 3'(RING_MHZ / (2 * TRACE_MHZ_24));
  localparam logic [2:0] HALF_12 = 3'(RING_MHZ / (2 * TRACE_MHZ_12));
  localparam logic [2:0] HALF_6 = 3'(RING_MHZ / (2 * TRACE_MHZ_6));

  // Bits in one byte, and index of its last half period
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [4:0] LAST_DATA_HALF = 5'(2 * BITS_PER_BYTE - 1);

  // Idle level of both pins
  localparam logic IDLE_LEVEL = 1'b1;

  // Control register contents, bits 6:0
  typedef struct packed {
    logic [2:0] gap;
    logic [1:0] divsel;
    logic edge_sel;
    logic en;
  } stbt_ctrl_s;

  localparam stbt_ctrl_s CTRL_RST = '{gap: 3'h0, divsel: 2'h0,
                                      edge_sel: 1'b0, en: 1'b0};

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stbt_req_s;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_GAP
  } stbt_state_e;

endpackage : stbt_pkg

`default_nettype wire

// ---- logic/stbt_tick_gen.sv ----
// Trace clock half-period tick generator.
// Assumes the ring oscillator level is synchronous to ref_clk.
`default_nettype none

module stbt_tick_gen (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic ring_osc_48m, // Ring oscillator level
  input wire logic run, // Count only while a transfer or its gap runs
  input wire logic [1:0] divsel, // Divider select
  output logic half_tick // One pulse per trace half period
);
  import stbt_pkg::*;

  logic osc_q;
  logic next_osc_q;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [2:0] half_len;
  logic osc_rise;

  // Half period length and oscillator edge count
  always_comb begin
    unique case (divsel)
      DIVSEL_24: half_len = HALF_24;
      DIVSEL_12: half_len = HALF_12;
      default: half_len = HALF_6; // Reserved code runs as 6 MHz
    endcase
    osc_rise = ring_osc_48m & ~osc_q;
    next_osc_q = ring_osc_48m;
    next_cnt = cnt;
    half_tick = 1'b0;
    if (!run) begin
      next_cnt = 3'h0;
    end else if (osc_rise) begin
      if (cnt + 3'h1 >= half_len) begin
        next_cnt = 3'h0;
        half_tick = ce;
      end else begin
        next_cnt = cnt + 3'h1;
      end
    end
  end

  // Counter registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      osc_q <= 1'b0;
      cnt <= 3'h0;
    end else if (ce) begin
      osc_q <= next_osc_q;
      cnt <= next_cnt;
    end
  end

endmodule : stbt_tick_gen

`default_nettype wire

// ---- logic/stbt_shifter.sv ----
// Parallel-to-serial converter driving the trace clock and data pins.
// Assumes the sequencer gives load, step and park one at a time.
`default_nettype none

module stbt_shifter (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic park, // Force both pins to idle
  input wire logic load, // Load byte, present bit 0
  input wire logic [7:0] byte_in, // Byte to send
  input wire logic start_clk, // Clock level of first half period
  input wire logic step, // End of a half period
  input wire logic next_bit, // Step also moves to next bit
  output logic trace_clk_out, // Trace clock pin
  output logic trace_data_out // Trace data pin
);
  import stbt_pkg::*;

  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic next_clk;
  logic next_data;

  // Shift and pin levels
  always_comb begin
    next_shreg = shreg;
    next_clk = trace_clk_out;
    next_data = trace_data_out;
    if (park) begin
      next_clk = IDLE_LEVEL;
      next_data = IDLE_LEVEL;
    end else if (load) begin
      next_shreg = byte_in;
      next_clk = start_clk;
      next_data = byte_in[0]; // LSB first
    end else if (step) begin
      next_clk = ~trace_clk_out;
      if (next_bit) begin
        next_shreg = {1'b0, shreg[7:1]};
        next_data = shreg[1]; // Changes on the selected edge
      end
    end
  end

  // Pin and shift registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shreg <= DATA_RST;
      trace_clk_out <= IDLE_LEVEL;
      trace_data_out <= IDLE_LEVEL;
    end else if (ce) begin
      shreg <= next_shreg;
      trace_clk_out <= next_clk;
      trace_data_out <= next_data;
    end
  end

endmodule : stbt_shifter

`default_nettype wire

// ---- logic/stbt_top.sv ----
// Serial trace byte transmitter: registers, transfer sequencer, pins.
// Assumes a register port master that holds a write until ready is high,
// and a ring oscillator level synchronous to ref_clk.
`default_nettype none

module stbt_top (
  input wire logic ref_clk, // System clock, 250 MHz
  input wire logic srst, // Main well reset, synchronous
  input wire logic ce, // Clock enable, freezes all state
  input wire logic ring_osc_48m, // 48 MHz ring oscillator level
  input wire stbt_pkg::stbt_req_s reg_req, // Register request
  output logic reg_ready, // Request taken this cycle
  output logic [7:0] reg_rdata, // Read data, registered
  output logic reg_rvalid, // Read data valid pulse
  output logic trace_busy, // Transfer or gap in progress
  output logic trace_clk_out, // Trace clock pin
  output logic trace_data_out // Trace data pin
);
  import stbt_pkg::*;

  // Register state
  logic [7:0] trace_byte_out;
  logic [7:0] next_trace_byte_out;
  stbt_ctrl_s trace_port_control;
  stbt_ctrl_s next_trace_port_control;

  // Read return state
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;

  // Sequencer state
  stbt_state_e state;
  stbt_state_e next_state;
  logic [4:0] half_cnt;
  logic [4:0] next_half_cnt;

  // Decode and control strobes
  logic hit_data;
  logic hit_ctrl;
  logic data_wr;
  logic ctrl_wr;
  logic half_tick;
  logic park;
  logic load;
  logic step;
  logic next_bit;
  logic [4:0] gap_last;

  // Address decode
  assign hit_data = (reg_req.addr == OFS_DATA);
  assign hit_ctrl = (reg_req.addr == OFS_CTRL);

  // Hold off data writes while a byte or its gap is in flight
  assign reg_ready = !(reg_req.wr && hit_data && state != ST_IDLE);
  assign data_wr = reg_req.wr && hit_data && reg_ready;
  assign ctrl_wr = reg_req.wr && hit_ctrl;

  // Last half period of the inter-packet gap, 2*(N+1)-1
  assign gap_last = {1'b0, trace_port_control.gap, 1'b1};

  assign trace_busy = (state != ST_IDLE);

  // Register writes and read return
  always_comb begin
    next_trace_byte_out = trace_byte_out;
    next_trace_port_control = trace_port_control;
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = reg_req.rd;
    if (data_wr) begin
      next_trace_byte_out = reg_req.wdata;
    end
    if (ctrl_wr) begin
      next_trace_port_control.gap = reg_req.wdata[GAP_MSB:GAP_LSB];
      next_trace_port_control.divsel =
        reg_req.wdata[DIV_MSB:DIV_LSB];
      next_trace_port_control.edge_sel = reg_req.wdata[EDGE_BIT];
      next_trace_port_control.en = reg_req.wdata[EN_BIT];
    end
    if (reg_req.rd) begin
      if (hit_data) begin
        next_reg_rdata = trace_byte_out;
      end else if (hit_ctrl) begin
        next_reg_rdata = {1'b0, trace_port_control}; // Bit 7 reads 0
      end else begin
        next_reg_rdata = 8'h00;
      end
    end
  end

  // Register file
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trace_byte_out <= DATA_RST;
      trace_port_control <= CTRL_RST;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      trace_byte_out <= next_trace_byte_out;
      trace_port_control <= next_trace_port_control;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  // Transfer sequencer
  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt;
    park = 1'b0;
    load = 1'b0;
    step = 1'b0;
    next_bit = 1'b0;
    if (!trace_port_control.en) begin
      next_state = ST_IDLE;
      next_half_cnt = 5'h00;
      park = 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (data_wr) begin
            next_state = ST_SEND;
            next_half_cnt = 5'h00;
            load = 1'b1;
          end
        end
        ST_SEND: begin
          if (half_tick) begin
            if (half_cnt == LAST_DATA_HALF) begin
              next_state = ST_GAP; // Exactly one byte
              next_half_cnt = 5'h00;
              park = 1'b1;
            end else begin
              step = 1'b1;
              next_bit = half_cnt[0]; // New bit after two halves
              next_half_cnt = half_cnt + 5'h01;
            end
          end
        end
        ST_GAP: begin
          if (half_tick) begin
            if (half_cnt == gap_last) begin
              next_state = ST_IDLE;
              next_half_cnt = 5'h00;
            end else begin
              next_half_cnt = half_cnt + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      half_cnt <= 5'h00;
    end else if (ce) begin
      state <= next_state;
      half_cnt <= next_half_cnt;
    end
  end

  // Trace clock timing from the ring oscillator
  stbt_tick_gen u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .ring_osc_48m(ring_osc_48m),
    .run(state != ST_IDLE),
    .divsel(trace_port_control.divsel),
    .half_tick(half_tick)
  );

  // Edge select 0 starts high so bits change on rising edges
  stbt_shifter u_shift (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .park(park),
    .load(load),
    .byte_in(reg_req.wdata),
    .start_clk(~trace_port_control.edge_sel),
    .step(step),
    .next_bit(next_bit),
    .trace_clk_out(trace_clk_out),
    .trace_data_out(trace_data_out)
  );

  // No interrupt output exists on this block

endmodule : stbt_top

`default_nettype wire

// ---- tb/stbt_props.sv ----
// Checker on the trace transmitter top ports, bound below.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none
module stbt_props
  import stbt_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic ce, // Enable
  input wire logic ring_osc_48m, // Oscillator
  input wire stbt_pkg::stbt_req_s reg_req, // Request
  input wire logic reg_ready, // Taken
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  input wire logic trace_busy, // Busy
  input wire logic trace_clk_out, // Clock pin
  input wire logic trace_data_out // Data pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_q;
  logic edge_q;
  logic ctrl_wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Control write taken
  assign ctrl_wr = ce && reg_req.wr && reg_ready && reg_req.addr == OFS_CTRL;
  // Copies of enable and edge select
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_q <= 1'b0;
      edge_q <= 1'b0;
    end else if (ctrl_wr) begin
      en_q <= reg_req.wdata[EN_BIT];
      edge_q <= reg_req.wdata[EDGE_BIT];
    end
  end
  // Data write taken while idle
  sequence start_s;
    ce && reg_req.wr && reg_ready && reg_req.addr == OFS_DATA && !trace_busy;
  endsequence
  // Capture edge inside a packet
  sequence sample_s;
    trace_busy && $past(trace_busy) && $changed(trace_clk_out)
      && trace_clk_out == edge_q;
  endsequence
  idle_pins_a: assert property (
    !trace_busy |-> trace_clk_out && trace_data_out)
    else $error("pins not high while idle");
  start_bit_a: assert property (
    start_s ##0 en_q |=> trace_busy && trace_clk_out == !edge_q
      && trace_data_out == $past(reg_req.wdata[0]))
    else $error("transfer start wrong");
  no_start_a: assert property (
    start_s ##0 !en_q |=> !trace_busy)
    else $error("transfer started while disabled");
  write_hold_a: assert property (
    reg_ready == !(reg_req.wr && reg_req.addr == OFS_DATA && trace_busy))
    else $error("ready wrong");
  sample_stable_a: assert property (
    sample_s |-> $stable(trace_data_out))
    else $error("data moved on capture edge");
  read_valid_a: assert property (
    ce && reg_req.rd |=> reg_rvalid)
    else $error("no read valid");
  unmapped_zero_a: assert property (
    ce && reg_req.rd && reg_req.addr != OFS_DATA && reg_req.addr != OFS_CTRL
      |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reset_clear_a: assert property (disable iff (1'b0)
    srst |=> trace_clk_out && trace_data_out && !trace_busy
      && !reg_rvalid && reg_rdata == 8'h00)
    else $error("reset did not clear");
endmodule : stbt_props

bind stbt_top stbt_props i_props (.ref_clk(ref_clk), .srst(srst), .ce(ce),
  .ring_osc_48m(ring_osc_48m), .reg_req(reg_req), .reg_ready(reg_ready),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .trace_busy(trace_busy),
  .trace_clk_out(trace_clk_out), .trace_data_out(trace_data_out));
`default_nettype wire

// ---- tb/stbt_capture_model.sv ----
// Capture side of the trace pins: rebuilds each byte.
// Assumes edge select matches the control register.
`default_nettype none
module stbt_capture_model (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Clears bit count
  input wire logic edge_sel, // Shift edge in use
  input wire logic trace_clk_out, // Trace clock pin
  input wire logic trace_data_out, // Trace data pin
  output logic [7:0] cap_byte // Last whole byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_q = 1'b1;
  logic [7:0] sh;
  int cnt = 0;
  // Sample on the edge opposite the shift edge, LSB first
  always @(posedge ref_clk) begin
    clk_q <= trace_clk_out;
    if (srst) begin
      cnt <= 0;
    end else if (clk_q != trace_clk_out && trace_clk_out == edge_sel) begin
      sh <= {trace_data_out, sh[7:1]};
      cnt <= (cnt + 1) % 8;
      // Eighth bit completes the byte
      if (cnt == 7) begin
        cap_byte <= {trace_data_out, sh[7:1]};
      end
    end
  end
endmodule : stbt_capture_model
`default_nettype wire

// ---- tb/serial_trace_byte_tx_tb.sv ----
// Self-checking bench for the serial trace byte transmitter.
// Assumes the checker and capture model are compiled first.
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module serial_trace_byte_tx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stbt_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ring_osc_48m = 1'b0;
  stbt_req_s req = '0;
  logic reg_ready, reg_rvalid, trace_busy, trace_clk_out, trace_data_out;
  logic [7:0] reg_rdata, cap_byte;
  logic edge_sel = 1'b0, clk_q = 1'b1, osc_q = 1'b0;
  logic ce = 1'b1;
  int n_errors = 0, checks = 0, acc = 0, oc = 0, per = 0, bc = 0;
  stbt_top i_dut (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .ring_osc_48m(ring_osc_48m), .reg_req(req), .reg_ready(reg_ready),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .trace_busy(trace_busy),
    .trace_clk_out(trace_clk_out), .trace_data_out(trace_data_out));
  stbt_capture_model i_cap (.ref_clk(ref_clk), .srst(srst),
    .edge_sel(edge_sel), .trace_clk_out(trace_clk_out),
    .trace_data_out(trace_data_out), .cap_byte(cap_byte));
  // Clock at 250 MHz
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Oscillator level at 48 MHz
  always @(posedge ref_clk) begin
    acc <= (acc + 96) % 250;
    if (acc + 96 >= 250) ring_osc_48m <= ~ring_osc_48m;
  end
  // Oscillator rises per trace period and while busy
  always @(negedge ref_clk) begin
    osc_q <= ring_osc_48m;
    clk_q <= trace_clk_out;
    if (ring_osc_48m && !osc_q) begin
      oc <= oc + 1;
      bc <= bc + int'(trace_busy);
    end
    if (clk_q && !trace_clk_out) begin
      per <= oc;
      oc <= 0;
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    do begin
      @(negedge ref_clk);
      n++;
    end while (reg_ready !== 1'b1 && n < 2000);
    @(posedge ref_clk);
    req.wr <= 1'b0;
    if (n >= 2000) begin
      n_errors++;
      test_done();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("rdata", ex, reg_rdata)
  endtask : rd
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (trace_busy !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      n_errors++;
      test_done();
    end
  endtask : wait_idle
  // Main sequence
  initial begin : main
    logic [7:0] c, b;
    int h, b0;
    logic [2:0] p;
    logic f;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    rd(OFS_DATA, 8'h00);
    rd(OFS_CTRL, 8'h00);
    rd(8'h08, 8'h00);
    wr(OFS_DATA, 8'h3C);
    repeat (40) @(negedge ref_clk);
    `CHK("busy", 1'b0, trace_busy)
    rd(OFS_DATA, 8'h3C);
    for (int i = 0; i < 8; i++) begin
      c = {1'b0, 3'(i), 2'(i >> 1), 1'(i), 1'b1};
      b = 8'h96 ^ 8'(i * 37);
      h = (i < 2) ? 1 : (i < 4) ? 2 : 4;
      edge_sel <= c[1];
      wr(OFS_CTRL, c);
      rd(OFS_CTRL, c);
      b0 = bc;
      wr(OFS_DATA, b);
      wait_idle();
      `CHK("byte", b, cap_byte)
      `CHK("period", 2 * h, per)
      `CHK("gap", 1'b1, (bc - b0 - (18 + 2 * i) * h) inside {[-1:1]})
    end
    wr(OFS_DATA, 8'h5A);
    wr(OFS_DATA, 8'hC3);
    `CHK("first", 8'h5A, cap_byte)
    wait_idle();
    `CHK("second", 8'hC3, cap_byte)
    // Clock enable low freezes a running byte
    wr(OFS_DATA, 8'hE7);
    repeat (10) @(posedge ref_clk);
    ce <= 1'b0;
    @(negedge ref_clk);
    p = {trace_busy, trace_clk_out, trace_data_out};
    f = 1'b0;
    repeat (40) begin
      @(negedge ref_clk);
      if ({trace_busy, trace_clk_out, trace_data_out} !== p) f = 1'b1;
    end
    `CHK("frozen", 1'b0, f)
    @(posedge ref_clk);
    ce <= 1'b1;
    wait_idle();
    `CHK("byte", 8'hE7, cap_byte)
    // Reset in mid byte, while bit 0 still holds the pin low
    wr(OFS_DATA, 8'h80);
    repeat (30) @(negedge ref_clk);
    `CHK("mid", 2'b10, {trace_busy, trace_data_out})
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    `CHK("pins", 2'b11, {trace_clk_out, trace_data_out})
    rd(OFS_CTRL, 8'h00);
    rd(OFS_DATA, 8'h00);
    test_done();
  end
endmodule : serial_trace_byte_tx_tb
`default_nettype wire
